// ---- pkg/edid_rep_map.svh ----
// constants for the shared edid store: sizes, vendor block layout, checksum place
// assumes the vendor block sits in the extension block at a fixed base (see module parameter)
`ifndef EDID_REP_MAP_SVH
`define EDID_REP_MAP_SVH

`define EDID_DEPTH 256
`define EDID_AW 8
`define VSDB_BASE_DEF 8'h84
`define VSDB_RID_LSB 8'h01
`define VSDB_RID_MID 8'h02
`define VSDB_RID_MSB 8'h03
`define VSDB_DEF_WX 8'h04
`define VSDB_DEF_YZ 8'h05
`define EXT_CSUM_ADDR 8'hff
`define LAST_ADDR 8'hff
`define SEL_W 4'h8
`define SEL_X 4'h4
`define SEL_Y 4'h2
`define SEL_Z 4'h1
`define NUM_PORTS 4
`define SYNC_W 18
`define SYNC_ENABLE 0
`define SYNC_HOTPLUG 1
`define SYNC_SRC_LSB 2
`define SYNC_LOC_LSB 10

`endif

// ---- pkg/edid_rep_pkg.sv ----
// types shared by the edid replicator and its bench
// assumes edid_rep_map.svh is on the include path
package edid_rep_pkg;
  `include "edid_rep_map.svh"

  typedef enum logic [1:0] {CP_IDLE, CP_ASK, CP_DONE} copy_state_type;

  typedef struct packed {
    logic req;
    logic [7:0] addr;
  } rd_req_type;

  typedef struct packed {
    logic scl;
    logic sda;
  } ddc_pins_type;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } preload_type;

  typedef struct packed {
    logic [`EDID_DEPTH-1:0][7:0] mem;
    copy_state_type cst;
    logic [7:0] cpAddr;
    logic loaded;
    logic pend;
    logic hotPrev;
    logic [`SYNC_W-1:0] s1;
    logic [`SYNC_W-1:0] s2;
    logic [`SYNC_W-1:0] s3;
    logic [`SYNC_W-1:0] q;
    logic [3:0][7:0] rdData;
    logic [3:0] rdValid;
    logic [3:0] hpd;
    logic eepRd;
    logic [7:0] srcOe;
    logic [7:0] locOe;
    logic [7:0] srcHold;
    logic [7:0] locHold;
  } state_type;
endpackage

// ---- design/edid_port_address_replicator.sv ----
// shared edid store serving four ddc read ports with per-port physical address
// assumes port-side i2c slaves issue byte reads, and an eeprom reader answers byte fetches
//
// Operation
// - one 256-byte store, read by all four ports at once
// - registration id bytes return the fixed identifier, not stored override bytes
// - identifier returned least significant byte first in vendor bytes 1..3
// - each port gets its own checksum reflecting its physical address
// - checksum assumes identifier in bytes 1..3 and includes default bytes 4, 5
// - address is W.X.Y.Z nibbles; byte 4 holds W:X, byte 5 holds Y:Z
// - byte 1 holds port A:B override nibbles, byte 2 port C:D
// - byte 3 low nibble one-hot picks which field the port nibble replaces
// - unselected fields come from the defaults
// - each ddc path buffered both ways, keeping arbitration; a far-side clock stretch already under way is lost
// - after power-up or first hot plug copy eeprom to store, hot plug held low
`timescale 1ns/1ps
`default_nettype none
`include "edid_rep_map.svh"

module edid_port_address_replicator #(
  parameter logic [7:0] VSDB_BASE = `VSDB_BASE_DEF,
  parameter logic [23:0] REG_ID = 24'h5a3c01 // arbitrary value
) (
  input wire logic core_clk, // 20 MHz core clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic replEnable, // pin: high lets the copy master run
  input wire logic hotPlug, // pin: hot plug seen from the sink side
  input wire logic [3:0] hpdRequest, // hot plug level wanted per port
  output logic [3:0] hpdOut, // hot plug per port, low during a copy
  output logic copyBusy, // store being filled from the eeprom
  input wire edid_rep_pkg::rd_req_type [3:0] rdReq, // byte read per port
  output logic [3:0][7:0] rdData, // read byte per port
  output logic [3:0] rdValid, // one-cycle pulse with rdData
  output logic eepRd, // fetch request to the eeprom reader
  output logic [7:0] eepAddr, // byte address of the fetch
  input wire logic eepAck, // fetch answered this cycle
  input wire logic [7:0] eepData, // fetched byte
  input wire edid_rep_pkg::preload_type preload, // controller write into the store
  input wire edid_rep_pkg::ddc_pins_type [3:0] srcIn, // source-side ddc levels
  output logic [7:0] srcOut, // source-side drive value, always low
  output logic [7:0] srcOe, // source-side pull-down enables
  input wire edid_rep_pkg::ddc_pins_type [3:0] locIn, // device-side ddc levels
  output logic [7:0] locOut, // device-side drive value, always low
  output logic [7:0] locOe // device-side pull-down enables
);
  import edid_rep_pkg::*;

  state_type cur_ff;
  state_type nxt_cur;

  // byte seen by port p at address a
  function automatic logic [7:0] portByte(input logic [1:0] p, input logic [7:0] a,
                                          input logic [`EDID_DEPTH-1:0][7:0] m);
    logic [7:0] b1;
    logic [7:0] b2;
    logic [3:0] sel;
    logic [3:0] ovr;
    logic [15:0] dflt;
    logic [15:0] addr;
    logic [7:0] csum;
    b1 = m[VSDB_BASE + `VSDB_RID_LSB];
    b2 = m[VSDB_BASE + `VSDB_RID_MID];
    sel = m[VSDB_BASE + `VSDB_RID_MSB][3:0];
    dflt = {m[VSDB_BASE + `VSDB_DEF_WX], m[VSDB_BASE + `VSDB_DEF_YZ]};
    case (p)
      2'd0: ovr = b1[7:4];
      2'd1: ovr = b1[3:0];
      2'd2: ovr = b2[7:4];
      default: ovr = b2[3:0];
    endcase
    addr = dflt;
    case (sel)
      `SEL_W: addr[15:12] = ovr;
      `SEL_X: addr[11:8] = ovr;
      `SEL_Y: addr[7:4] = ovr;
      `SEL_Z: addr[3:0] = ovr;
      default: addr = dflt;
    endcase
    // stored sum already counts the identifier and defaults; swap defaults for this port
    csum = 8'(m[`EXT_CSUM_ADDR] + dflt[15:8] + dflt[7:0] - addr[15:8] - addr[7:0]);
    if (a == 8'(VSDB_BASE + `VSDB_RID_LSB)) begin
      portByte = REG_ID[7:0];
    end else if (a == 8'(VSDB_BASE + `VSDB_RID_MID)) begin
      portByte = REG_ID[15:8];
    end else if (a == 8'(VSDB_BASE + `VSDB_RID_MSB)) begin
      portByte = REG_ID[23:16];
    end else if (a == 8'(VSDB_BASE + `VSDB_DEF_WX)) begin
      portByte = addr[15:8];
    end else if (a == 8'(VSDB_BASE + `VSDB_DEF_YZ)) begin
      portByte = addr[7:0];
    end else if (a == `EXT_CSUM_ADDR) begin
      portByte = csum;
    end else begin
      portByte = m[a];
    end
  endfunction

  logic [`SYNC_W-1:0] pinRaw;
  logic [7:0] srcQ;
  logic [7:0] locQ;
  logic enQ;
  logic hotQ;

  always_comb begin
    for (int i = 0; i < `NUM_PORTS; i++) begin
      pinRaw[`SYNC_SRC_LSB + 2*i] = srcIn[i].scl;
      pinRaw[`SYNC_SRC_LSB + 2*i + 1] = srcIn[i].sda;
      pinRaw[`SYNC_LOC_LSB + 2*i] = locIn[i].scl;
      pinRaw[`SYNC_LOC_LSB + 2*i + 1] = locIn[i].sda;
    end
    pinRaw[`SYNC_ENABLE] = replEnable;
    pinRaw[`SYNC_HOTPLUG] = hotPlug;
  end

  assign srcQ = cur_ff.q[`SYNC_SRC_LSB +: 8];
  assign locQ = cur_ff.q[`SYNC_LOC_LSB +: 8];
  assign enQ = cur_ff.q[`SYNC_ENABLE];
  assign hotQ = cur_ff.q[`SYNC_HOTPLUG];

  always_comb begin
    nxt_cur = cur_ff;
    // three-stage capture; a level counts once stages two and three agree
    nxt_cur.s1 = pinRaw;
    nxt_cur.s2 = cur_ff.s1;
    nxt_cur.s3 = cur_ff.s2;
    for (int i = 0; i < `SYNC_W; i++) begin
      if (cur_ff.s2[i] == cur_ff.s3[i]) begin
        nxt_cur.q[i] = cur_ff.s3[i];
      end
    end

    // pass a low across only when this side is not the one we are driving, so the
    // buffer never latches itself; wired-and of both sides keeps stretching and arbitration
    // after letting go of a side its synced level lags; that low is our own echo until it
    // reads high again, so it is not passed back (a far-side stretch already under way is lost)
    for (int i = 0; i < 8; i++) begin
      nxt_cur.locOe[i] = !srcQ[i] && !cur_ff.srcOe[i] && !cur_ff.srcHold[i];
      nxt_cur.srcOe[i] = !locQ[i] && !cur_ff.locOe[i] && !cur_ff.locHold[i];
      nxt_cur.srcHold[i] = (cur_ff.srcOe[i] || cur_ff.srcHold[i]) && !srcQ[i];
      nxt_cur.locHold[i] = (cur_ff.locOe[i] || cur_ff.locHold[i]) && !locQ[i];
    end

    // reads: every port served from the one store in the same cycle
    for (int p = 0; p < `NUM_PORTS; p++) begin
      nxt_cur.rdValid[p] = rdReq[p].req;
      if (rdReq[p].req) begin
        nxt_cur.rdData[p] = portByte(2'(p), rdReq[p].addr, cur_ff.mem);
      end
    end

    // copy master: first hot plug after power-up starts it if not yet loaded
    nxt_cur.hotPrev = hotQ;
    nxt_cur.eepRd = 1'b0;
    case (cur_ff.cst)
      CP_IDLE: begin
        if (cur_ff.pend && enQ) begin
          nxt_cur.cst = CP_ASK;
          nxt_cur.cpAddr = 8'h00;
          nxt_cur.pend = 1'b0;
          nxt_cur.eepRd = 1'b1;
        end else if (!enQ && preload.wr) begin
          nxt_cur.mem[preload.addr] = preload.data;
          nxt_cur.loaded = 1'b1;
        end
      end
      CP_ASK: begin
        nxt_cur.eepRd = !eepAck || (cur_ff.cpAddr != `LAST_ADDR);
        if (eepAck) begin
          nxt_cur.mem[cur_ff.cpAddr] = eepData;
          nxt_cur.cpAddr = 8'(cur_ff.cpAddr + 8'h01);
          if (cur_ff.cpAddr == `LAST_ADDR) begin
            nxt_cur.cst = CP_DONE;
          end
        end
      end
      CP_DONE: begin
        nxt_cur.loaded = 1'b1;
        nxt_cur.cst = CP_IDLE;
      end
      default: nxt_cur.cst = CP_IDLE;
    endcase
    // a hot plug edge in the cycle a copy starts still wins over the clear
    if (hotQ && !cur_ff.hotPrev && !cur_ff.loaded) begin
      nxt_cur.pend = 1'b1;
    end

    nxt_cur.hpd = (nxt_cur.cst == CP_IDLE) ? hpdRequest : 4'h0;

    if (!rst_n) begin
      nxt_cur = '0;
      nxt_cur.cst = CP_IDLE;
      nxt_cur.pend = 1'b1;
      nxt_cur.s1 = '1;
      nxt_cur.s2 = '1;
      nxt_cur.s3 = '1;
      nxt_cur.q = '1;
      nxt_cur.hotPrev = 1'b1;
      // enable sync starts low, so a copy waits for the enable pin itself
      nxt_cur.s1[`SYNC_ENABLE] = 1'b0;
      nxt_cur.s2[`SYNC_ENABLE] = 1'b0;
      nxt_cur.s3[`SYNC_ENABLE] = 1'b0;
      nxt_cur.q[`SYNC_ENABLE] = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    cur_ff <= nxt_cur;
  end

  assign hpdOut = cur_ff.hpd;
  assign copyBusy = (cur_ff.cst != CP_IDLE);
  assign rdData = cur_ff.rdData;
  assign rdValid = cur_ff.rdValid;
  assign eepRd = cur_ff.eepRd;
  assign eepAddr = cur_ff.cpAddr;
  assign srcOut = 8'h00;
  assign locOut = 8'h00;
  assign srcOe = cur_ff.srcOe;
  assign locOe = cur_ff.locOe;

endmodule

`default_nettype wire

// ---- dv/eeprom_reader_model.sv ----
// eeprom reader standing on the far side of the fetch port
// assumes fetches are byte wide and acked one at a time
`timescale 1ns/1ps
`default_nettype none
module eeprom_reader_model (
  input wire logic core_clk, // clock
  input wire logic rst_n, // reset
  input wire logic eepRd, // fetch wanted
  input wire logic [7:0] eepAddr, // fetch address
  input wire logic slow, // high adds two wait cycles
  input wire logic [7:0] lastByte, // byte served at the top address
  output logic eepAck, // byte answered
  output logic [7:0] eepData // fetched byte
);
  logic [1:0] waitCnt;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      eepAck <= 1'b0;
      eepData <= 8'h00;
      waitCnt <= 2'h0;
    end else if (eepRd && !eepAck && waitCnt == (slow ? 2'h2 : 2'h0)) begin
      eepAck <= 1'b1;
      eepData <= (eepAddr == 8'hff) ? lastByte : eepAddr ^ 8'h5a;
      waitCnt <= 2'h0;
    end else begin
      eepAck <= 1'b0;
      eepData <= ~eepData;
      if (eepRd && !eepAck) waitCnt <= waitCnt + 2'h1;
    end
  end
endmodule
`default_nettype wire

// ---- dv/edid_rep_sva.sv ----
// port checker for the edid replicator
// assumes it is bound to the top module
`timescale 1ns/1ps
`default_nettype none
module edid_rep_sva #(
  parameter logic [7:0] VSDB_BASE = 8'h84,
  parameter logic [23:0] REG_ID = 24'h5a3c01 // arbitrary value
) (
  input wire logic core_clk, // clock
  input wire logic rst_n, // reset
  input wire logic [3:0] hpdOut, // hot plug out
  input wire logic copyBusy, // copy running
  input wire edid_rep_pkg::rd_req_type [3:0] rdReq, // reads
  input wire logic [3:0][7:0] rdData, // read bytes
  input wire logic [3:0] rdValid, // read pulses
  input wire logic eepRd, // fetch
  input wire logic [7:0] eepAddr, // fetch address
  input wire logic eepAck, // fetch ack
  input wire edid_rep_pkg::ddc_pins_type [3:0] srcIn, // source levels
  input wire logic [7:0] srcOut, // source drive
  input wire logic [7:0] srcOe, // source enables
  input wire logic [7:0] locOut, // local drive
  input wire logic [7:0] locOe // local enables
);
  import edid_rep_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_RD_LAT: assert property (rdReq[1].req |=> rdValid[1]) else $error("late read");
  AST_RID_LSB: assert property (rdReq[0].req && rdReq[0].addr == VSDB_BASE + 8'h01 |=>
    rdData[0] == REG_ID[7:0]) else $error("id byte 1");
  AST_RID_MID: assert property (rdReq[1].req && rdReq[1].addr == VSDB_BASE + 8'h02 |=>
    rdData[1] == REG_ID[15:8]) else $error("id byte 2");
  AST_RID_MSB: assert property (rdReq[2].req && rdReq[2].addr == VSDB_BASE + 8'h03 |=>
    rdData[2] == REG_ID[23:16]) else $error("id byte 3");
  AST_SHARED: assert property (rdReq[0].req && rdReq[3].req && rdReq[0].addr == rdReq[3].addr
    && rdReq[0].addr < VSDB_BASE |=> rdData[0] == rdData[3]) else $error("ports differ");
  AST_HPD_LOW: assert property (copyBusy |-> hpdOut == 4'h0) else $error("hpd high");
  AST_EEP_START: assert property ($rose(eepRd) |-> eepAddr == 8'h00) else $error("start");
  AST_EEP_STEP: assert property (eepRd && eepAck && eepAddr != 8'hff |=>
    eepAddr == $past(eepAddr) + 8'h01) else $error("step");
  AST_DDC_ECHO: assert property ($fell(srcIn[0].sda) && !srcOe[1] |-> ##[1:8] locOe[1])
    else $error("no echo");
  AST_OPEN_DRAIN: assert property (srcOut == 8'h00 && locOut == 8'h00)
    else $error("drive high");
  COV_COPY: cover property ($fell(copyBusy));
  COV_ALL4: cover property (rdValid == 4'hf);
  COV_ECHO: cover property ($rose(locOe[1]));
endmodule
bind edid_port_address_replicator edid_rep_sva #(.VSDB_BASE(VSDB_BASE), .REG_ID(REG_ID)) sva_u (
  .core_clk(core_clk), .rst_n(rst_n), .hpdOut(hpdOut), .copyBusy(copyBusy), .rdReq(rdReq),
  .rdData(rdData), .rdValid(rdValid), .eepRd(eepRd), .eepAddr(eepAddr), .eepAck(eepAck),
  .srcIn(srcIn), .srcOut(srcOut), .srcOe(srcOe), .locOut(locOut), .locOe(locOe));
`default_nettype wire

// ---- dv/test_edid_port_address_replicator.sv ----
// self-checking bench for the edid replicator
// assumes the eeprom model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module test_edid_port_address_replicator;
  import edid_rep_pkg::*;
  localparam logic [7:0] VB = 8'h84;
  localparam logic [23:0] RID = 24'h3b7e21; // arbitrary value
  logic core_clk = 0, rst_n = 0, replEnable = 1, hotPlug = 0, eepAck, copyBusy, eepRd;
  logic [3:0] hpdRequest = 4'ha, hpdOut, rdValid;
  logic [7:0] eepAddr, eepData, srcOut, srcOe, locOut, locOe;
  logic [3:0][7:0] rdData;
  rd_req_type [3:0] rdReq = '0;
  preload_type preload = '0;
  ddc_pins_type [3:0] srcIn = '1, locIn = '1;
  logic [7:0] img [256];
  logic [7:0] expQ [4][$];
  logic [3:0] sels [6] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h0, 4'h3};
  logic [31:0] rng = 32'he839;
  int error_cnt = 0, compares = 0;
  edid_port_address_replicator #(.VSDB_BASE(VB), .REG_ID(RID)) dut_u (.core_clk(core_clk),
    .rst_n(rst_n), .replEnable(replEnable), .hotPlug(hotPlug), .hpdRequest(hpdRequest),
    .hpdOut(hpdOut), .copyBusy(copyBusy), .rdReq(rdReq), .rdData(rdData), .rdValid(rdValid),
    .eepRd(eepRd), .eepAddr(eepAddr), .eepAck(eepAck), .eepData(eepData), .preload(preload),
    .srcIn(srcIn), .srcOut(srcOut), .srcOe(srcOe), .locIn(locIn), .locOut(locOut),
    .locOe(locOe));
  eeprom_reader_model mdl_u (.core_clk(core_clk), .rst_n(rst_n), .eepRd(eepRd),
    .eepAddr(eepAddr), .slow(eepAddr[1]), .lastByte(img[255]), .eepAck(eepAck),
    .eepData(eepData));
  initial forever #25 core_clk = ~core_clk;
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [7:0] expb(int p, logic [7:0] a);
    logic [7:0] b1, b2;
    logic [3:0] nib;
    logic [15:0] ad;
    b1 = img[VB + 8'h01];
    b2 = img[VB + 8'h02];
    nib = (p == 0) ? b1[7:4] : (p == 1) ? b1[3:0] : (p == 2) ? b2[7:4] : b2[3:0];
    ad = {img[VB + 8'h04], img[VB + 8'h05]};
    case (img[VB + 8'h03][3:0])
      4'h8: ad[15:12] = nib;
      4'h4: ad[11:8] = nib;
      4'h2: ad[7:4] = nib;
      4'h1: ad[3:0] = nib;
      default: ;
    endcase
    if (a == VB + 8'h01) return RID[7:0];
    if (a == VB + 8'h02) return RID[15:8];
    if (a == VB + 8'h03) return RID[23:16];
    if (a == VB + 8'h04) return ad[15:8];
    if (a == VB + 8'h05) return ad[7:0];
    if (a == 8'hff) return extSum(ad);
    return img[a];
  endfunction
  // checksum that makes the extension block, as one port sees it, sum to zero
  function automatic logic [7:0] extSum(logic [15:0] ad);
    logic [7:0] s;
    s = 8'h00;
    for (int a = 128; a < 255; a++) begin
      case (a - int'(VB))
        1: s += RID[7:0];
        2: s += RID[15:8];
        3: s += RID[23:16];
        4: s += ad[15:8];
        5: s += ad[7:0];
        default: s += img[a];
      endcase
    end
    return 8'h00 - s;
  endfunction
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic rd4(logic [7:0] a);
    tick(1);
    for (int p = 0; p < 4; p++) begin
      rdReq[p] = '{1'b1, a};
      expQ[p].push_back(expb(p, a));
    end
    tick(1);
    rdReq = '0;
  endtask
  task automatic rdAll();
    for (int i = 1; i <= 5; i++) rd4(VB + i[7:0]);
    rd4(8'hff);
    rd4(8'h10);
  endtask
  task automatic pl(logic [7:0] a, logic [7:0] d);
    tick(1);
    preload = '{1'b1, a, d};
    img[a] = d;
    tick(1);
    preload = '0;
  endtask
  task automatic waitBusy(logic lvl);
    int n;
    for (n = 0; n < 3000 && copyBusy !== lvl; n++) tick(1);
    if (n == 3000) begin
      error_cnt++;
      conclude();
    end
  endtask
  always @(negedge core_clk)
    for (int p = 0; p < 4; p++)
      if (rdValid[p] === 1'b1) begin
        if (expQ[p].size() > 0) chk(rdData[p], expQ[p].pop_front());
        else chk({7'h0, rdValid[p]}, 8'h00);
      end
  initial begin
    int n;
    for (int i = 0; i < 256; i++) img[i] = i[7:0] ^ 8'h5a;
    img[255] = extSum({img[VB + 8'h04], img[VB + 8'h05]});
    tick(8);
    rst_n = 1;
    waitBusy(1);
    chk({4'h0, hpdOut}, 8'h00);
    waitBusy(0);
    tick(3);
    chk({4'h0, hpdOut}, {4'h0, hpdRequest});
    rdAll();
    $display("test copy and default reads done");
    replEnable = 0;
    tick(5);
    for (int i = 0; i < 6; i++) begin
      rng = xs(rng);
      pl(VB + 8'h01, rng[7:0]);
      pl(VB + 8'h02, rng[15:8]);
      pl(VB + 8'h03, {rng[23:20], sels[i]});
      pl(VB + 8'h04, (sels[i] == 4'h8) ? {rng[31:28], 4'h0} : rng[31:24]);
      pl(VB + 8'h05, (sels[i] == 4'h8) ? 8'h00 : rng[7:0] ^ rng[31:24]);
      pl(8'hff, extSum({img[VB + 8'h04], img[VB + 8'h05]}));
      rdAll();
    end
    $display("test override selects done");
    srcIn[0].sda = 1'b0;
    for (n = 0; n < 10 && locOe[1] !== 1'b1; n++) tick(1);
    chk({7'h0, locOe[1]}, 8'h01);
    // local line follows our pull-down like a wired line, and lags on release
    locIn[0].sda = 1'b0;
    tick(2);
    srcIn[0].sda = 1'b1;
    for (n = 0; n < 10 && locOe[1] !== 1'b0; n++) tick(1);
    chk({7'h0, locOe[1]}, 8'h00);
    for (n = 0; n < 8; n++) begin
      tick(1);
      chk({7'h0, srcOe[1]}, 8'h00);
      if (n == 1) begin
        locIn[0].sda = 1'b1;
      end
    end
    $display("test ddc buffer done");
    hotPlug = 1'b1;
    tick(8);
    chk({7'h0, copyBusy}, 8'h00);
    $display("test late hot plug done");
    tick(3);
    conclude();
  end
endmodule
`default_nettype wire
